// [serial_remote_node.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_remote_node (
    input  wire logic       sys_clk_i,  // shared clock
    input  wire logic       send_i,     // start one character
    input  wire logic [7:0] data_i,     // character to send
    input  wire logic [2:0] fault_i,    // noise, bad stop, bad parity
    input  wire logic       odd_i,      // odd parity selected
    input  wire logic       tx_write_i, // device queued a character
    output logic            bit_done_o, // start bit sampled
    output logic      [6:0] samples_o,  // start bit samples
    output logic            ready_o,    // character assembled
    output logic      [7:0] data_o,     // character data
    output logic            parity_o,   // parity bit
    output logic            stop_o,     // stop sample
    output logic            tx_load_o,  // buffer moved to shifter
    output logic            tx_busy_o   // shifting out
);
    logic [1:0] step_reg   = 2'h0;
    logic [7:0] char_reg   = 8'h00;
    logic [2:0] fault_reg  = 3'h0;
    logic [3:0] tx_cnt_reg = 4'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // frame sequencing: start bit first, character one cycle later
    always_ff @(posedge sys_clk_i) begin
        step_reg <= send_i ? 2'h1 : ((step_reg == 2'h1) ? 2'h2 : 2'h0);
        if (send_i) begin
            char_reg  <= data_i;
            fault_reg <= fault_i;
        end
    end
    // outside the frame data and parity carry inverted values, stop is low and samples read 7'h55, so a stale copy never matches
    assign bit_done_o = (step_reg == 2'h1);
    assign samples_o  = bit_done_o ? {3'h0, fault_reg[0], 3'h0} : 7'h55;
    assign ready_o    = (step_reg == 2'h2);
    assign data_o     = ready_o ? char_reg : ~char_reg;
    assign parity_o   = ^char_reg ^ odd_i ^ fault_reg[2] ^ ~ready_o;
    assign stop_o     = ready_o & ~fault_reg[1];
    ////////////////////////////////////////////////////////////////////////////////
    // transmitter: load two cycles after the write pulse, then shift for five
    always_ff @(posedge sys_clk_i) begin
        if (tx_write_i) begin
            tx_cnt_reg <= 4'h6;
        end else if (tx_cnt_reg != 4'h0) begin
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
        end
    end
    assign tx_load_o = (tx_cnt_reg == 4'h5);
    assign tx_busy_o = (tx_cnt_reg != 4'h0) && (tx_cnt_reg <= 4'h5);
endmodule : serial_remote_node
`default_nettype wire

// [serial_status_flags.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_status_flags (
    input  wire logic        sys_clk_i,       // 50 MHz clock
    input  wire logic        reset_i,         // sync reset, high
    input  wire logic [15:0] addr_i,          // register address
    input  wire logic [7:0]  wr_data_i,       // write data
    input  wire logic        wr_i,            // write strobe
    input  wire logic        rd_i,            // read strobe
    output logic      [7:0]  rd_data_o,       // read data, next cycle
    input  wire logic        tx_load_i,       // buffer moved to shifter
    input  wire logic        tx_busy_i,       // data/preamble/break going out
    output logic      [7:0]  tx_data_o,       // transmit buffer value
    output logic             tx_write_o,      // data register written
    output logic             tx_on_o,         // transmitter enable
    output logic             break_queue_o,   // break request level
    output logic             nine_bit_o,      // nine-bit characters
    output logic             parity_enable_o, // parity on
    output logic             parity_odd_o,    // odd parity
    input  wire logic        rxd_i,           // receive pin
    input  wire logic        bit_tick_i,      // one pulse per bit time
    input  wire logic        rx_start_done_i, // start bit finished
    input  wire logic        rx_stop_done_i,  // stop bit finished
    input  wire logic        rx_bit_done_i,   // one bit sampled
    input  wire logic        rx_bit_start_i,  // that bit was the start bit
    input  wire logic [6:0]  rx_samples_i,    // samples of that bit
    input  wire logic        rx_char_ready_i, // character assembled
    input  wire logic [7:0]  rx_data_i,       // character data
    input  wire logic        rx_parity_i,     // received parity bit
    input  wire logic        rx_stop_i,       // stop bit sample
    output logic      [7:0]  status_o         // live status flags
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic reg_hit(input logic [15:0] a, input logic [7:0] ofs);
        reg_hit = ((a[15:8] == serial_status_pkg::BLOCKING_BASE) ||
                   (a[15:8] == serial_status_pkg::NONBLOCK_BASE)) && (a[7:0] == ofs);
    endfunction : reg_hit

    // start bit holds seven samples, other bits three
    function automatic logic bit_noisy(input logic [6:0] s, input logic start);
        if (start) begin
            bit_noisy = !((&s) || (~|s));
        end else begin
            bit_noisy = !((&s[2:0]) || (~|s[2:0]));
        end
    endfunction : bit_noisy

    ////////////////////////////////////////////////////////////////////
    // decode

    logic [7:0] flags_reg;
    logic [7:0] arm_reg;
    logic [4:0] ctrl_one_reg;
    logic [3:0] ctrl_two_reg;
    logic [7:0] rx_data_reg;
    logic       st_hit;
    logic       st_rd;
    logic       st_wr;
    logic       data_rd;
    logic       data_wr;
    logic       two_wr;
    logic       one_wr;

    assign st_hit  = reg_hit(addr_i, serial_status_pkg::STATUS_OFS);
    assign st_rd   = rd_i && st_hit;
    assign st_wr   = wr_i && st_hit;
    assign data_rd = rd_i && reg_hit(addr_i, serial_status_pkg::DATA_OFS);
    assign data_wr = wr_i && reg_hit(addr_i, serial_status_pkg::DATA_OFS);
    assign one_wr  = wr_i && reg_hit(addr_i, serial_status_pkg::CTRL_ONE_OFS);
    assign two_wr  = wr_i && reg_hit(addr_i, serial_status_pkg::CTRL_TWO_OFS);

    // read mux; the status path has no write branch at all
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_i) begin
            if (st_hit) begin
                rd_data_o <= flags_reg;
            end else if (reg_hit(addr_i, serial_status_pkg::DATA_OFS)) begin
                rd_data_o <= rx_data_reg;
            end else if (reg_hit(addr_i, serial_status_pkg::CTRL_ONE_OFS)) begin
                rd_data_o <= {3'h0, ctrl_one_reg};
            end else if (reg_hit(addr_i, serial_status_pkg::CTRL_TWO_OFS)) begin
                rd_data_o <= {4'h0, ctrl_two_reg};
            end else begin
                rd_data_o <= 8'h00; // unmapped reads as zero
            end
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers

    logic txon_rise;
    logic brk_write1;

    assign txon_rise  = two_wr && wr_data_i[serial_status_pkg::TXON_BIT] &&
                        !ctrl_two_reg[serial_status_pkg::TXON_BIT];
    assign brk_write1 = two_wr && wr_data_i[serial_status_pkg::BRK_BIT];

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_one_reg <= serial_status_pkg::CTRL_RESET[4:0];
        end else if (one_wr) begin
            ctrl_one_reg <= wr_data_i[4:0];
        end
    end

    // break level stays as written; transmitter repeats breaks while high
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_two_reg <= serial_status_pkg::CTRL_RESET[3:0];
        end else if (two_wr) begin
            ctrl_two_reg <= wr_data_i[3:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tx_on_o         <= 1'b0;
            break_queue_o   <= 1'b0;
            nine_bit_o      <= 1'b0;
            parity_enable_o <= 1'b0;
            parity_odd_o    <= 1'b0;
        end else begin
            tx_on_o         <= two_wr ? wr_data_i[serial_status_pkg::TXON_BIT] : tx_on_o;
            break_queue_o   <= two_wr ? wr_data_i[serial_status_pkg::BRK_BIT] : break_queue_o;
            nine_bit_o      <= one_wr ? wr_data_i[serial_status_pkg::NINE_BIT] : nine_bit_o;
            parity_enable_o <= one_wr ? wr_data_i[serial_status_pkg::PEN_BIT] : parity_enable_o;
            parity_odd_o    <= one_wr ? wr_data_i[serial_status_pkg::PODD_BIT] : parity_odd_o;
        end
    end

    // transmit buffer handoff
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tx_data_o  <= 8'h00;
            tx_write_o <= 1'b0;
        end else begin
            tx_write_o <= data_wr;
            if (data_wr) begin
                tx_data_o <= wr_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clear sequence: a status read arms only the flags it saw set

    logic empty_clr;
    logic done_clr;
    logic full_clr;
    logic idle_clr;
    logic ovr_clr;
    logic noise_clr;
    logic frame_clr;
    logic par_clr;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            arm_reg <= 8'h00;
        end else if (st_rd) begin
            arm_reg <= flags_reg;
        end else begin
            arm_reg <= arm_reg & ~{empty_clr, done_clr, full_clr, idle_clr,
                                   ovr_clr, noise_clr, frame_clr, par_clr};
        end
    end

    assign empty_clr = data_wr && arm_reg[serial_status_pkg::EMPTY_BIT];
    assign done_clr  = arm_reg[serial_status_pkg::DONE_BIT] &&
                       (data_wr || txon_rise || brk_write1);
    assign full_clr  = data_rd && arm_reg[serial_status_pkg::FULL_BIT];
    assign idle_clr  = data_rd && arm_reg[serial_status_pkg::IDLE_BIT];
    assign ovr_clr   = data_rd && arm_reg[serial_status_pkg::OVR_BIT];
    assign noise_clr = data_rd && arm_reg[serial_status_pkg::NOISE_BIT];
    assign frame_clr = data_rd && arm_reg[serial_status_pkg::FRAME_BIT];
    assign par_clr   = data_rd && arm_reg[serial_status_pkg::PAR_BIT];

    ////////////////////////////////////////////////////////////////////
    // transmit flags

    logic done_hold_reg;
    logic done_set;

    // after a clear, hold off until the transmitter reports activity,
    // otherwise an idle shifter would re-set the flag before it starts
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            done_hold_reg <= 1'b0;
        end else if (done_clr) begin
            done_hold_reg <= 1'b1;
        end else if (tx_busy_i) begin
            done_hold_reg <= 1'b0;
        end
    end

    assign done_set = flags_reg[serial_status_pkg::EMPTY_BIT] && !tx_busy_i &&
                      !done_hold_reg && !done_clr;

    ////////////////////////////////////////////////////////////////////
    // receive capture

    logic noise_pend_reg;
    logic noise_now;
    logic rx_accept;
    logic rx_lost;
    logic par_bad;

    assign noise_now = rx_bit_done_i && bit_noisy(rx_samples_i, rx_bit_start_i);
    // a read that empties the buffer in the same cycle makes room
    assign rx_accept = rx_char_ready_i &&
                       !(flags_reg[serial_status_pkg::FULL_BIT] && !full_clr);
    assign rx_lost   = rx_char_ready_i && !rx_accept;
    assign par_bad   = parity_enable_o &&
                       (rx_parity_i != ((^rx_data_i) ^ parity_odd_o));

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            noise_pend_reg <= 1'b0;
        end else if (rx_char_ready_i) begin
            noise_pend_reg <= 1'b0;
        end else if (noise_now) begin
            noise_pend_reg <= 1'b1;
        end
    end

    // a lost character never reaches the data register
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rx_data_reg <= 8'h00;
        end else if (rx_accept) begin
            rx_data_reg <= rx_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // idle line: pin sync and quiet counter

    logic rxd_s1_reg;
    logic rxd_s2_reg;
    logic rxd_s3_reg;
    logic line_reg;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
            rxd_s3_reg <= 1'b1;
            line_reg   <= 1'b1;
        end else begin
            rxd_s1_reg <= rxd_i;
            rxd_s2_reg <= rxd_s1_reg;
            rxd_s3_reg <= rxd_s2_reg;
            if (rxd_s2_reg == rxd_s3_reg) begin
                line_reg <= rxd_s2_reg;
            end
        end
    end

    serial_status_pkg::quiet_state_type q_state_reg;
    logic [3:0] q_count_reg;
    logic [3:0] q_len;
    logic       idle_set;
    logic       idle_ok_reg;
    logic       q_done;

    assign q_len  = nine_bit_o ? serial_status_pkg::CHAR_LEN_9 :
                                 serial_status_pkg::CHAR_LEN_8;
    assign q_done = (q_state_reg == serial_status_pkg::QUIET_COUNT) && bit_tick_i &&
                    line_reg && ((q_count_reg + 4'h1) == q_len);
    assign idle_set = q_done && idle_ok_reg;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q_state_reg <= serial_status_pkg::QUIET_OFF;
            q_count_reg <= 4'h0;
        end else if (rx_start_done_i) begin
            q_count_reg <= 4'h0;
            if (ctrl_one_reg[serial_status_pkg::QSEL_BIT]) begin
                q_state_reg <= serial_status_pkg::QUIET_WAIT_STOP;
            end else begin
                q_state_reg <= serial_status_pkg::QUIET_COUNT;
            end
        end else begin
            case (q_state_reg)
                serial_status_pkg::QUIET_WAIT_STOP: begin
                    if (rx_stop_done_i) begin
                        q_state_reg <= serial_status_pkg::QUIET_COUNT;
                        q_count_reg <= 4'h0;
                    end
                end
                serial_status_pkg::QUIET_COUNT: begin
                    if (!line_reg) begin
                        q_count_reg <= 4'h0; // any low bit restarts the count
                    end else if (q_done) begin
                        q_state_reg <= serial_status_pkg::QUIET_OFF;
                        q_count_reg <= 4'h0;
                    end else if (bit_tick_i) begin
                        q_count_reg <= q_count_reg + 4'h1;
                    end
                end
                serial_status_pkg::QUIET_OFF: begin
                    q_count_reg <= 4'h0;
                end
                default: begin
                    q_state_reg <= serial_status_pkg::QUIET_OFF;
                    q_count_reg <= 4'h0;
                end
            endcase
        end
    end

    // idle may fire once per character that reached the buffer
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            idle_ok_reg <= 1'b0;
        end else begin
            idle_ok_reg <= rx_accept || (idle_ok_reg && !idle_set);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags: a set in the clear cycle wins, except complete, whose set its clear blocks; software writes never land

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            flags_reg <= serial_status_pkg::STATUS_RESET;
        end else begin
            flags_reg[serial_status_pkg::EMPTY_BIT] <= tx_load_i ||
                (flags_reg[serial_status_pkg::EMPTY_BIT] && !empty_clr);
            flags_reg[serial_status_pkg::DONE_BIT] <= done_set ||
                (flags_reg[serial_status_pkg::DONE_BIT] && !done_clr);
            flags_reg[serial_status_pkg::FULL_BIT] <= rx_accept ||
                (flags_reg[serial_status_pkg::FULL_BIT] && !full_clr);
            flags_reg[serial_status_pkg::IDLE_BIT] <= idle_set ||
                (flags_reg[serial_status_pkg::IDLE_BIT] && !idle_clr);
            flags_reg[serial_status_pkg::OVR_BIT] <= rx_lost ||
                (flags_reg[serial_status_pkg::OVR_BIT] && !ovr_clr);
            flags_reg[serial_status_pkg::NOISE_BIT] <= (rx_accept && (noise_pend_reg || noise_now)) ||
                (flags_reg[serial_status_pkg::NOISE_BIT] && !noise_clr);
            flags_reg[serial_status_pkg::FRAME_BIT] <= (rx_accept && !rx_stop_i) ||
                (flags_reg[serial_status_pkg::FRAME_BIT] && !frame_clr);
            flags_reg[serial_status_pkg::PAR_BIT] <= (rx_accept && par_bad) ||
                (flags_reg[serial_status_pkg::PAR_BIT] && !par_clr);
        end
    end

    assign status_o = flags_reg;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_full_seen;
        st_rd && flags_reg[serial_status_pkg::FULL_BIT];
    endsequence

    sequence s_full_taken;
        data_rd && !rx_char_ready_i;
    endsequence

    // a complete flag that is already set cannot move, so only a pending set is excluded
    a_status_write_dead: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        st_wr && !tx_load_i && (flags_reg[serial_status_pkg::DONE_BIT] || !done_set) &&
            !rx_char_ready_i && !idle_set |=> $stable(flags_reg))
        else $error("status write changed flags");

    a_empty_on_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        tx_load_i |=> flags_reg[serial_status_pkg::EMPTY_BIT])
        else $error("buffer empty not set on load");

    a_empty_fall_cause: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(flags_reg[serial_status_pkg::EMPTY_BIT]) |-> $past(data_wr && arm_reg[serial_status_pkg::EMPTY_BIT]))
        else $error("buffer empty cleared without sequence");

    a_done_fall_cause: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(flags_reg[serial_status_pkg::DONE_BIT]) |-> $past(done_clr))
        else $error("complete cleared without sequence");

    a_full_clear_seq: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_full_seen ##[1:2] s_full_taken |=> !flags_reg[serial_status_pkg::FULL_BIT])
        else $error("buffer full not cleared");

    a_idle_once: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(flags_reg[serial_status_pkg::IDLE_BIT]) |-> $past(idle_ok_reg && q_done))
        else $error("idle set without new character");

    a_overrun_drop: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rx_lost |=> flags_reg[serial_status_pkg::OVR_BIT] && $stable(rx_data_reg))
        else $error("overrun not handled");

    a_noise_with_full: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rx_accept && (noise_pend_reg || noise_now) |=> flags_reg[serial_status_pkg::NOISE_BIT] &&
            flags_reg[serial_status_pkg::FULL_BIT])
        else $error("noise not flagged");

    a_frame_error: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rx_accept && !rx_stop_i |=> flags_reg[serial_status_pkg::FRAME_BIT])
        else $error("framing error missed");

    a_parity_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rx_accept && !parity_enable_o && !flags_reg[serial_status_pkg::PAR_BIT]
            |=> !flags_reg[serial_status_pkg::PAR_BIT])
        else $error("parity error while disabled");

    a_status_readback: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        st_rd |=> rd_data_o == $past(flags_reg))
        else $error("status read data wrong");

endmodule : serial_status_flags
`default_nettype wire

// [serial_status_flags_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_status_flags_tb_top;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wr_data_i = 8'h00, rd_data_o, tx_data_o, status_o, rx_data, data_q = 8'h00, seen;
    logic wr_i = 1'b0, rd_i = 1'b0, send_q = 1'b0, tx_load, tx_busy, tx_write_o, tick_q = 1'b0;
    logic bit_done, ready, parity, stop;
    logic [4:0] ctl;
    logic [2:0] fault_q = 3'h0;
    logic [6:0] samples;
    int checked = 0, mismatches = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    // the receive pin stays high; stop-done rides on the character strobe, bit ticks come from the bench
    serial_status_flags dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .tx_load_i(tx_load), .tx_busy_i(tx_busy), .tx_data_o(tx_data_o), .tx_write_o(tx_write_o),
        .tx_on_o(ctl[4]), .break_queue_o(ctl[3]), .nine_bit_o(ctl[2]), .parity_enable_o(ctl[1]),
        .parity_odd_o(ctl[0]), .rxd_i(1'b1), .bit_tick_i(tick_q), .rx_start_done_i(bit_done),
        .rx_stop_done_i(ready),
        .rx_bit_done_i(bit_done), .rx_bit_start_i(bit_done), .rx_samples_i(samples),
        .rx_char_ready_i(ready), .rx_data_i(rx_data), .rx_parity_i(parity), .rx_stop_i(stop),
        .status_o(status_o));
    serial_remote_node node_u (.sys_clk_i(sys_clk_i), .send_i(send_q), .data_i(data_q),
        .fault_i(fault_q), .odd_i(ctl[0]), .tx_write_i(tx_write_o), .bit_done_o(bit_done),
        .samples_o(samples), .ready_o(ready), .data_o(rx_data), .parity_o(parity),
        .stop_o(stop), .tx_load_o(tx_load), .tx_busy_o(tx_busy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // bus cycles end 1 ns past the edge, so the next one starts on a fresh edge
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= wr;
        rd_i <= ~wr;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 seen = rd_data_o;
    endtask : bus
    task automatic send(input logic [7:0] d, input logic [2:0] f);
        @(posedge sys_clk_i);
        send_q <= 1'b1;
        data_q <= d;
        fault_q <= f;
        @(posedge sys_clk_i);
        send_q <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask : send
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("status", status_o, 8'hc0);
        bus(1'b0, 16'h0e1c, 8'h00);
        chk("rd blocking", seen, 8'hc0);
        bus(1'b1, 16'h0e1c, 8'hff);
        bus(1'b0, 16'h0f1c, 8'h00);
        chk("rd nonblocking", seen, 8'hc0);
    endtask : t_reset
    task automatic t_overrun();
        send(8'h5a, 3'h0);
        chk("full", status_o, 8'he0);
        bus(1'b0, 16'h0f1c, 8'h00);
        send(8'ha5, 3'h0);
        chk("overrun", status_o, 8'he8);
        bus(1'b0, 16'h0e1f, 8'h00);
        chk("kept data", seen, 8'h5a);
        chk("unarmed", status_o, 8'hc8);
        bus(1'b0, 16'h0e1c, 8'h00);
        bus(1'b0, 16'h0e1f, 8'h00);
        chk("cleared", status_o, 8'hc0);
    endtask : t_overrun
    task automatic t_errors();
        bus(1'b1, 16'h0e1a, 8'h03);
        chk("mode", {3'h0, ctl}, 8'h03);
        for (int i = 0; i < 3; i++) begin
            send(8'h3c, 3'h1 << i);
            chk("error flag", status_o, 8'he0 | (8'h04 >> i));
            bus(1'b0, 16'h0e1c, 8'h00);
            bus(1'b0, 16'h0e1f, 8'h00);
            chk("error clear", status_o, 8'hc0);
        end
    endtask : t_errors
    task automatic t_tx();
        bus(1'b0, 16'h0e1c, 8'h00);
        bus(1'b1, 16'h0e1f, 8'h33);
        chk("tx clear", status_o & 8'hc0, 8'h00);
        chk("tx data", tx_data_o, 8'h33);
        repeat (12) @(posedge sys_clk_i);
        #1;
        chk("tx done", status_o, 8'hc0);
        bus(1'b0, 16'h0e1c, 8'h00);
        bus(1'b1, 16'h0e1b, 8'h08);
        chk("preamble", status_o, 8'h80);
        bus(1'b1, 16'h0e1b, 8'h09);
        chk("break", {3'h0, ctl}, 8'h1b);
    endtask : t_tx
    // one-cycle bit ticks two cycles apart, then one settled cycle before returning
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            tick_q <= 1'b1;
            @(posedge sys_clk_i);
            tick_q <= 1'b0;
        end
        @(posedge sys_clk_i);
        #1;
    endtask : ticks
    task automatic t_idle();
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, 16'h0e1a, (m == 0) ? 8'h00 : 8'h14);
            chk("mode", {3'h0, ctl}, (m == 0) ? 8'h18 : 8'h1c);
            send(8'h11, 3'h0);
            ticks((m == 0) ? 9 : 10);
            chk("idle early", status_o & 8'h10, 8'h00);
            ticks(1);
            chk("idle set", status_o & 8'h10, 8'h10);
            bus(1'b0, 16'h0e1c, 8'h00);
            bus(1'b0, 16'h0e1f, 8'h00);
            ticks(11);
            chk("idle once", status_o & 8'h30, 8'h00);
        end
    endtask : t_idle
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        #1;
        t_reset();
        t_overrun();
        t_errors();
        t_tx();
        t_idle();
        close_out();
    end
    // watchdog well beyond the roughly two hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        mismatches++;
        close_out();
    end
endmodule : serial_status_flags_tb_top
`default_nettype wire

// [serial_status_pkg.sv]
`default_nettype none
package serial_status_pkg;
    // address decode: high byte picks the access path
    localparam logic [7:0] BLOCKING_BASE  = 8'h0e;
    localparam logic [7:0] NONBLOCK_BASE  = 8'h0f;
    localparam logic [7:0] CTRL_ONE_OFS   = 8'h1a;
    localparam logic [7:0] CTRL_TWO_OFS   = 8'h1b;
    localparam logic [7:0] STATUS_OFS     = 8'h1c;
    localparam logic [7:0] DATA_OFS       = 8'h1f;
    // status flag positions
    localparam int EMPTY_BIT = 7;
    localparam int DONE_BIT  = 6;
    localparam int FULL_BIT  = 5;
    localparam int IDLE_BIT  = 4;
    localparam int OVR_BIT   = 3;
    localparam int NOISE_BIT = 2;
    localparam int FRAME_BIT = 1;
    localparam int PAR_BIT   = 0;
    // control one fields
    localparam int NINE_BIT  = 4;
    localparam int QSEL_BIT  = 2;
    localparam int PEN_BIT   = 1;
    localparam int PODD_BIT  = 0;
    // control two fields
    localparam int TXON_BIT  = 3;
    localparam int BRK_BIT   = 0;
    localparam logic [7:0] STATUS_RESET = 8'hc0;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    // idle character time in bit times
    localparam logic [3:0] CHAR_LEN_8 = 4'ha;
    localparam logic [3:0] CHAR_LEN_9 = 4'hb;
    typedef enum logic [1:0] {
        QUIET_OFF       = 2'b00,
        QUIET_WAIT_STOP = 2'b01,
        QUIET_COUNT     = 2'b10
    } quiet_state_type;
endpackage : serial_status_pkg
`default_nettype wire
